// File: include/llcr_defines.vh
// Register offsets, field positions and reset values for the link-layer crypto/test bank
`ifndef LLCR_DEFINES_VH
`define LLCR_DEFINES_VH
`define LLCR_ADDR_W 32
`define LLCR_OFF_PUBPTR 32'h400000b0
`define LLCR_OFF_PRIVPTR 32'h400000b4
`define LLCR_OFF_COUNTS 32'h400000b8
`define LLCR_OFF_CIPHCTL 32'h400000c0
`define LLCR_OFF_KEY0 32'h400000c4
`define LLCR_OFF_KEY1 32'h400000c8
`define LLCR_OFF_KEY2 32'h400000cc
`define LLCR_OFF_KEY3 32'h400000d0
`define LLCR_OFF_BLKPTR 32'h400000d4
`define LLCR_OFF_TXMIC 32'h400000d8
`define LLCR_OFF_RXMIC 32'h400000dc
`define LLCR_OFF_TESTCTL 32'h400000e0
`define LLCR_RESET_WORD 32'h00000000
`define LLCR_RESET_PTR 16'h0000
`define LLCR_RESET_BYTE 8'h00
`define LLCR_RESET_LEN 9'h000
`define LLCR_START_BIT 0
`define LLCR_ENDLESS_RX_BIT 31
`define LLCR_ENDLESS_TX_BIT 15
`define LLCR_LEN_SRC_BIT 14
`define LLCR_SEQ_KIND_BIT 13
`define LLCR_PLD_SRC_BIT 12
`define LLCR_PRBS9_SEED 9'h1ff
`define LLCR_PRBS15_SEED 15'h7fff
`define LLCR_BYTE_ONE 9'h001
`define LLCR_BYTE_ZERO 9'h000
`endif

// File: core/llcr_regs.v
// Link-layer register slice: filter lists, cipher control, RF test payload generation
`timescale 1ns/1ns
`include "llcr_defines.vh"
module llcr_regs #(
  parameter DATA_W = 32,
  parameter LEN_W = 9
)
(
  input wire clk,
  input wire reset,
  input wire clkEn,
  input wire [`LLCR_ADDR_W-1:0] regAddr,
  input wire [DATA_W-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [DATA_W-1:0] regRdData,
  output wire [15:0] publicListStart,
  output wire [15:0] privateListStart,
  output wire [7:0] privateEntryCount,
  output wire [7:0] publicEntryCount,
  output wire cipherStart,
  output wire [127:0] cipherKey,
  output wire [15:0] cipherBlockAddr,
  input wire cipherDoneEvent,
  input wire [31:0] transmitMicIn,
  input wire [31:0] receiveMicIn,
  output wire endlessReceive,
  output wire endlessTransmit,
  input wire testMode,
  input wire [LEN_W-1:0] descriptorPayloadLength,
  output wire [LEN_W-1:0] payloadLength,
  input wire payloadStart,
  input wire payloadByteReq,
  input wire [7:0] structByte,
  output reg [7:0] payloadByte_r,
  output reg payloadByteValid_r,
  output wire payloadWrap
);

  reg [15:0] pubPtr_r;
  reg [15:0] privPtr_r;
  reg [7:0] privCnt_r;
  reg [7:0] pubCnt_r;
  reg start_r;
  reg [31:0] key0_r;
  reg [31:0] key1_r;
  reg [31:0] key2_r;
  reg [31:0] key3_r;
  reg [15:0] blkPtr_r;
  reg [31:0] txMic_r;
  reg [31:0] rxMic_r;
  reg endlessRx_r;
  reg endlessTx_r;
  reg lenSrc_r;
  reg seqKind_r;
  reg pldSrc_r;
  reg [LEN_W-1:0] testLen_r;
  reg [8:0] lfsr9_r;
  reg [14:0] lfsr15_r;
  reg [LEN_W-1:0] byteCnt_r;
  reg [DATA_W-1:0] rdNxt;
  reg [8:0] lfsr9Nxt;
  reg [14:0] lfsr15Nxt;
  reg [7:0] prbsByte;
  integer i;

  // Write decode, one helper so every register uses the same compare
  function isWr;
    input [`LLCR_ADDR_W-1:0] a;
    input [`LLCR_ADDR_W-1:0] off;
    begin
      isWr = (a == off);
    end
  endfunction

  // Per-register write strobes
  wire wrPub;
  wire wrPriv;
  wire wrCounts;
  wire wrCtl;
  wire wrKey0;
  wire wrKey1;
  wire wrKey2;
  wire wrKey3;
  wire wrBlk;
  wire wrTest;

  // Hardware event strobe
  wire doneEn;

  // clkEn folded in here so a frozen clock drops writes as well as events
  assign wrPub = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_PUBPTR);
  assign wrPriv = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_PRIVPTR);
  assign wrCounts = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_COUNTS);
  assign wrCtl = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_CIPHCTL);
  assign wrKey0 = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_KEY0);
  assign wrKey1 = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_KEY1);
  assign wrKey2 = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_KEY2);
  assign wrKey3 = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_KEY3);
  assign wrBlk = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_BLKPTR);
  assign wrTest = clkEn && regWrite && isWr(regAddr, `LLCR_OFF_TESTCTL);
  assign doneEn = clkEn && cipherDoneEvent;

  // Filter-list start pointers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pubPtr_r <= `LLCR_RESET_PTR;
      privPtr_r <= `LLCR_RESET_PTR;
    end
    else
    begin
      if (wrPub)
        pubPtr_r <= regWrData[15:0];
      if (wrPriv)
        privPtr_r <= regWrData[15:0];
    end
  end

  // Entry counts share one word, private count on top
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      privCnt_r <= `LLCR_RESET_BYTE;
      pubCnt_r <= `LLCR_RESET_BYTE;
    end
    else if (wrCounts)
    begin
      privCnt_r <= regWrData[15:8];
      pubCnt_r <= regWrData[7:0];
    end
  end

  // Done event beats a same-cycle write so a finished operation never looks busy
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      start_r <= 1'b0;
    else if (doneEn)
      start_r <= 1'b0;
    else if (wrCtl && regWrData[`LLCR_START_BIT])
      start_r <= 1'b1;
  end

  // Key words, lowest address holds key bits 31..0
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      key0_r <= `LLCR_RESET_WORD;
      key1_r <= `LLCR_RESET_WORD;
      key2_r <= `LLCR_RESET_WORD;
      key3_r <= `LLCR_RESET_WORD;
    end
    else
    begin
      if (wrKey0)
        key0_r <= regWrData[31:0];
      if (wrKey1)
        key1_r <= regWrData[31:0];
      if (wrKey2)
        key2_r <= regWrData[31:0];
      if (wrKey3)
        key3_r <= regWrData[31:0];
    end
  end

  // Cipher block pointer
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      blkPtr_r <= `LLCR_RESET_PTR;
    else if (wrBlk)
      blkPtr_r <= regWrData[15:0];
  end

  // MIC values are only captured by hardware, writes are ignored
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txMic_r <= `LLCR_RESET_WORD;
      rxMic_r <= `LLCR_RESET_WORD;
    end
    else if (doneEn)
    begin
      txMic_r <= transmitMicIn;
      rxMic_r <= receiveMicIn;
    end
  end

  // Endless receive and transmit flags
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      endlessRx_r <= 1'b0;
      endlessTx_r <= 1'b0;
    end
    else if (wrTest)
    begin
      endlessRx_r <= regWrData[`LLCR_ENDLESS_RX_BIT];
      endlessTx_r <= regWrData[`LLCR_ENDLESS_TX_BIT];
    end
  end

  // Payload selects and test length; only acted on in RF test mode
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lenSrc_r <= 1'b0;
      seqKind_r <= 1'b0;
      pldSrc_r <= 1'b0;
      testLen_r <= `LLCR_RESET_LEN;
    end
    else if (wrTest)
    begin
      lenSrc_r <= regWrData[`LLCR_LEN_SRC_BIT];
      seqKind_r <= regWrData[`LLCR_SEQ_KIND_BIT];
      pldSrc_r <= regWrData[`LLCR_PLD_SRC_BIT];
      testLen_r <= regWrData[LEN_W-1:0];
    end
  end

  // Read mux; reserved bits stay zero because only fields are placed
  always @*
  begin
    rdNxt = {DATA_W{1'b0}};
    if (regAddr == `LLCR_OFF_PUBPTR)
      rdNxt[15:0] = pubPtr_r;
    else if (regAddr == `LLCR_OFF_PRIVPTR)
      rdNxt[15:0] = privPtr_r;
    else if (regAddr == `LLCR_OFF_COUNTS)
      rdNxt[15:0] = {privCnt_r, pubCnt_r};
    else if (regAddr == `LLCR_OFF_CIPHCTL)
      rdNxt[`LLCR_START_BIT] = start_r;
    else if (regAddr == `LLCR_OFF_KEY0)
      rdNxt[31:0] = key0_r;
    else if (regAddr == `LLCR_OFF_KEY1)
      rdNxt[31:0] = key1_r;
    else if (regAddr == `LLCR_OFF_KEY2)
      rdNxt[31:0] = key2_r;
    else if (regAddr == `LLCR_OFF_KEY3)
      rdNxt[31:0] = key3_r;
    else if (regAddr == `LLCR_OFF_BLKPTR)
      rdNxt[15:0] = blkPtr_r;
    else if (regAddr == `LLCR_OFF_TXMIC)
      rdNxt[31:0] = txMic_r;
    else if (regAddr == `LLCR_OFF_RXMIC)
      rdNxt[31:0] = rxMic_r;
    else if (regAddr == `LLCR_OFF_TESTCTL)
    begin
      rdNxt[`LLCR_ENDLESS_RX_BIT] = endlessRx_r;
      rdNxt[`LLCR_ENDLESS_TX_BIT] = endlessTx_r;
      rdNxt[`LLCR_LEN_SRC_BIT] = lenSrc_r;
      rdNxt[`LLCR_SEQ_KIND_BIT] = seqKind_r;
      rdNxt[`LLCR_PLD_SRC_BIT] = pldSrc_r;
      rdNxt[LEN_W-1:0] = testLen_r;
    end
  end

  // Read data registered; unmapped addresses read zero
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      regRdData <= {DATA_W{1'b0}};
    else if (clkEn)
    begin
      if (regRead)
        regRdData <= rdNxt;
      else
        regRdData <= {DATA_W{1'b0}}; // Zero outside the slot keeps a shared bus clean
    end
  end

  // Filter-list outputs
  assign publicListStart = pubPtr_r;
  assign privateListStart = privPtr_r;
  assign privateEntryCount = privCnt_r;
  assign publicEntryCount = pubCnt_r;

  // Cipher outputs and endless receive/transmit flags
  assign cipherStart = start_r;
  assign cipherKey = {key3_r, key2_r, key1_r, key0_r};
  assign cipherBlockAddr = blkPtr_r;
  assign endlessReceive = endlessRx_r;
  assign endlessTransmit = endlessTx_r;

  // Length source only switches in test mode; descriptor length otherwise
  assign payloadLength = (testMode && lenSrc_r) ? testLen_r : descriptorPayloadLength;

  // Eight serial steps per byte, LSB first out of each register
  always @*
  begin
    lfsr9Nxt = lfsr9_r;
    lfsr15Nxt = lfsr15_r;
    prbsByte = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      prbsByte[i] = seqKind_r ? lfsr15Nxt[0] : lfsr9Nxt[0];
      lfsr9Nxt = {lfsr9Nxt[0] ^ lfsr9Nxt[4], lfsr9Nxt[8:1]};
      lfsr15Nxt = {lfsr15Nxt[0] ^ lfsr15Nxt[1] ^ lfsr15Nxt[2] ^ lfsr15Nxt[12]
        ^ lfsr15Nxt[13], lfsr15Nxt[14:1]};
    end
  end

  // Byte counter wraps at the chosen length whether endless tx is set or not
  assign payloadWrap = payloadByteReq && (byteCnt_r + `LLCR_BYTE_ONE >= payloadLength);

  // Generator only advances when its bytes are actually used
  wire prbsSel;
  wire byteTake;
  assign prbsSel = testMode && pldSrc_r;
  assign byteTake = clkEn && payloadByteReq && !payloadStart;

  // Seeds reload at each packet start so every packet opens the same way
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lfsr9_r <= `LLCR_PRBS9_SEED;
      lfsr15_r <= `LLCR_PRBS15_SEED;
    end
    else if (clkEn && payloadStart)
    begin
      lfsr9_r <= `LLCR_PRBS9_SEED;
      lfsr15_r <= `LLCR_PRBS15_SEED;
    end
    else if (byteTake && prbsSel)
    begin
      lfsr9_r <= lfsr9Nxt;
      lfsr15_r <= lfsr15Nxt;
    end
  end

  // Pattern repeats at test length in endless mode without PRBS
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      byteCnt_r <= `LLCR_BYTE_ZERO;
    else if (clkEn && payloadStart)
      byteCnt_r <= `LLCR_BYTE_ZERO;
    else if (byteTake && payloadWrap)
      byteCnt_r <= `LLCR_BYTE_ZERO;
    else if (byteTake)
      byteCnt_r <= byteCnt_r + `LLCR_BYTE_ONE;
  end

  // Output byte holds until the next request; valid is a one-cycle pulse
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      payloadByte_r <= 8'h00;
      payloadByteValid_r <= 1'b0;
    end
    else if (clkEn)
    begin
      payloadByteValid_r <= byteTake;
      if (byteTake)
        payloadByte_r <= prbsSel ? prbsByte : structByte;
    end
  end

endmodule

// File: dv/llcr_regs_assertions.sv
// Port-level checker for the link-layer register slice
`timescale 1ns/1ns
module llcr_regs_chk (
  input wire clk,
  input wire reset,
  input wire [31:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdData,
  input wire [15:0] publicListStart,
  input wire [7:0] privateEntryCount,
  input wire [7:0] publicEntryCount,
  input wire cipherStart,
  input wire [127:0] cipherKey,
  input wire cipherDoneEvent,
  input wire testMode,
  input wire [8:0] descriptorPayloadLength,
  input wire [8:0] payloadLength,
  input wire payloadStart,
  input wire payloadByteReq,
  input wire payloadByteValid_r
);
  // Single domain, checks muted in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Register writes land one cycle later
  pub_ptr_a: assert property (regWrite && regAddr == 32'h400000b0
    |=> publicListStart == $past(regWrData[15:0])) else $error("public pointer wrong");
  count_split_a: assert property (regWrite && regAddr == 32'h400000b8
    |=> {privateEntryCount, publicEntryCount} == $past(regWrData[15:0]))
    else $error("entry counts wrong");
  key_low_a: assert property (regWrite && regAddr == 32'h400000c4
    |=> cipherKey[31:0] == $past(regWrData)) else $error("key low word wrong");
  key_high_a: assert property (regWrite && regAddr == 32'h400000d0
    |=> cipherKey[127:96] == $past(regWrData)) else $error("key high word wrong");
  // Done wins over a start written in the same cycle
  start_set_a: assert property (regWrite && regAddr == 32'h400000c0 && regWrData[0]
    && !cipherDoneEvent |=> cipherStart) else $error("start not set");
  start_clear_a: assert property (cipherDoneEvent |=> !cipherStart)
    else $error("start not cleared");
  rd_idle_a: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data outside read slot");
  len_norm_a: assert property (!testMode |-> payloadLength == descriptorPayloadLength)
    else $error("length source wrong");
  byte_valid_a: assert property (payloadByteValid_r == $past(payloadByteReq && !payloadStart))
    else $error("byte valid wrong");
endmodule

// File: dv/test_llcr_regs.sv
// Self-checking bench for the link-layer register slice
`timescale 1ns/1ns
module test_llcr_regs;
  logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [31:0] regAddr = 32'h0, regWrData = 32'h0, regRdData;
  logic [31:0] transmitMicIn = 32'h0, receiveMicIn = 32'h0;
  logic [15:0] publicListStart, privateListStart, cipherBlockAddr;
  logic [7:0] privateEntryCount, publicEntryCount, structByte = 8'h0, payloadByte_r;
  logic cipherStart, cipherDoneEvent = 1'b0, endlessReceive, endlessTransmit, testMode = 1'b0;
  logic payloadStart = 1'b0, payloadByteReq = 1'b0, payloadByteValid_r, payloadWrap;
  logic [127:0] cipherKey;
  logic [8:0] descriptorPayloadLength = 9'h005, payloadLength;
  logic [14:0] lf;
  int error_cnt = 0;
  int checks = 0;
  llcr_regs u_llcr_regs (.clk, .reset, .clkEn, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .publicListStart, .privateListStart, .privateEntryCount, .publicEntryCount,
    .cipherStart, .cipherKey, .cipherBlockAddr, .cipherDoneEvent, .transmitMicIn,
    .receiveMicIn, .endlessReceive, .endlessTransmit, .testMode, .descriptorPayloadLength,
    .payloadLength, .payloadStart, .payloadByteReq, .structByte, .payloadByte_r,
    .payloadByteValid_r, .payloadWrap);
  always #5 clk = ~clk;
  task chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  // Bus cycles: strobe for one cycle, read data sampled in the slot after
  task wr(logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task rd(logic [31:0] a, logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("rdata", regRdData, e);
  endtask
  // Serial model, LSB of each byte is the first bit out
  function automatic logic [7:0] nb(logic k);
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b[i] = lf[0];
      if (k)
        lf = {lf[0] ^ lf[1] ^ lf[2] ^ lf[12] ^ lf[13], lf[14:1]};
      else
        lf[8:0] = {lf[0] ^ lf[4], lf[8:1]};
    end
    return b;
  endfunction
  task req(logic [7:0] e, logic w);
    @(posedge clk);
    payloadByteReq <= 1'b1;
    #1 chk("wrap", payloadWrap, w);
    @(posedge clk);
    payloadByteReq <= 1'b0;
    #1 chk("byte", {payloadByteValid_r, payloadByte_r}, {1'b1, e});
  endtask
  task restart;
    @(posedge clk);
    payloadStart <= 1'b1;
    @(posedge clk);
    payloadStart <= 1'b0;
  endtask
  // Whole window incl. the holes at bc and e4 reads zero
  task t_reset;
    for (int i = 0; i < 14; i++)
      rd(32'h400000b0 + 32'(4 * i), 32'h0);
  endtask
  task t_mask;
    static logic [31:0] a [5] = '{32'h400000b0, 32'h400000b4, 32'h400000b8, 32'h400000d4,
      32'h400000d8};
    static logic [31:0] m [5] = '{32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h0000ffff, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      wr(a[i], 32'hfedca5c3);
      rd(a[i], 32'hfedca5c3 & m[i]);
    end
    chk("ptrs", {publicListStart, privateListStart}, 32'ha5c3a5c3);
    chk("cnt", {privateEntryCount, publicEntryCount, cipherBlockAddr}, 32'ha5c3a5c3);
    wr(32'h400000e0, 32'hffffffff);
    rd(32'h400000e0, 32'h8000f1ff);
    chk("endless", {endlessReceive, endlessTransmit}, 2'b11);
    for (int i = 0; i < 4; i++)
      wr(32'h400000c4 + 32'(4 * i), 32'h11111111 * (i + 1));
    chk("key", cipherKey[127:96] ^ cipherKey[31:0], 32'h55555555);
    chk("key1", cipherKey[63:32] ^ cipherKey[95:64], 32'h11111111);
  endtask
  task t_ciph;
    @(posedge clk);
    transmitMicIn <= 32'h0badf00d;
    receiveMicIn <= 32'h600dcafe;
    wr(32'h400000c0, 32'hffffffff);
    chk("start", cipherStart, 32'h1);
    rd(32'h400000c0, 32'h1);
    @(posedge clk) cipherDoneEvent <= 1'b1;
    @(posedge clk) cipherDoneEvent <= 1'b0;
    #1 chk("start", cipherStart, 32'h0);
    rd(32'h400000d8, 32'h0badf00d);
    rd(32'h400000dc, 32'h600dcafe);
  endtask
  // Low clock enable freezes state; a write in that window is lost
  task t_freeze;
    @(posedge clk) clkEn <= 1'b0;
    wr(32'h400000b4, 32'h00001234);
    chk("freeze", privateListStart, 32'ha5c3);
    @(posedge clk) clkEn <= 1'b1;
    rd(32'h400000b4, 32'h0000a5c3);
  endtask
  // Generator source, length from test field
  task t_prbs(logic k);
    wr(32'h400000e0, {17'h0, 1'b1, k, 1'b1, 3'h0, 9'h003});
    chk("len", payloadLength, 32'h3);
    lf = 15'h7fff;
    restart;
    for (int i = 0; i < 3; i++)
      req(nb(k), i == 2);
  endtask
  // Endless control-structure pattern repeats every test length
  task t_struct;
    wr(32'h400000e0, {16'h0, 1'b1, 1'b1, 2'b00, 3'h0, 9'h003});
    @(posedge clk);
    structByte <= 8'h3c;
    restart;
    for (int i = 0; i < 4; i++)
      req(8'h3c, i == 2);
    @(posedge clk) testMode <= 1'b0;
    #1 chk("lensrc", payloadLength, 32'h5);
    @(posedge clk) testMode <= 1'b1;
    wr(32'h400000e0, 32'h0);
    chk("desc", payloadLength, 32'h5);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    testMode <= 1'b1;
    t_reset;
    t_mask;
    t_ciph;
    t_freeze;
    t_prbs(1'b0);
    t_prbs(1'b1);
    t_struct;
    end_sim;
  end
endmodule
bind llcr_regs llcr_regs_chk u_llcr_regs_chk (.clk, .reset, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .publicListStart, .privateEntryCount, .publicEntryCount, .cipherStart,
  .cipherKey, .cipherDoneEvent, .testMode, .descriptorPayloadLength, .payloadLength,
  .payloadStart, .payloadByteReq, .payloadByteValid_r);
